// [rtl/rmiu_pkg.sv]
// Package for the register move instruction unit: opcodes, fields, formats
// Assumes a 32-bit instruction word and a host pipeline that supplies operands
package rmiu_pkg;
    // ==========================================================
    // Opcode fields
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_FPU = 6'h11;
    localparam logic [5:0] OP_COPROC_TWO_OPCODE = 6'h12;
    localparam logic [4:0] SUB_MF = 5'h00;
    localparam logic [4:0] SUB_MFH = 5'h03;
    localparam logic [5:0] FN_COND_MOVE = 6'h01;
    localparam logic [5:0] FN_PROD_UP = 6'h10;
    localparam logic [5:0] FN_PROD_LO = 6'h12;
    localparam logic [5:0] FN_FP_MOV = 6'h06;
    // ==========================================================
    // Float formats
    localparam logic [4:0] FMT_SINGLE = 5'h10;
    localparam logic [4:0] FMT_DOUBLE = 5'h11;
    localparam logic [4:0] FMT_PAIRED = 5'h16;
    // ==========================================================
    // Architecture release and exception codes
    localparam logic [2:0] RELEASE_TWO = 3'h2;
    localparam logic [1:0] EXC_NONE = 2'h0;
    localparam logic [1:0] EXC_RESERVED = 2'h1;
    localparam logic [1:0] EXC_COP_UNUSABLE = 2'h2;
    localparam logic [1:0] EXC_UNIMPL_OP = 2'h3;
    // ==========================================================
    // Decoded operation kinds, one-hot
    typedef enum logic [7:0] {
        RMIU_OP_NONE = 8'h01,
        RMIU_OP_C2_WORD = 8'h02,
        RMIU_OP_FPR_UP = 8'h04,
        RMIU_OP_C2_UP = 8'h08,
        RMIU_OP_PROD_UP = 8'h10,
        RMIU_OP_PROD_LO = 8'h20,
        RMIU_OP_FP_MOV = 8'h40,
        RMIU_OP_MOV_IF_F = 8'h80
    } rmiu_op_t;
endpackage

// [rtl/rmiu_result_reg.sv]
// Result holding register for the register move instruction unit
// Assumes a single clock with a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module rmiu_result_reg #(
    parameter int W = 32
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_q <= '0;
        end else if (i_load) begin
            o_q <= i_d;
        end
    end
endmodule
`default_nettype wire

// [rtl/rmiu_core.sv]
// Register move instruction unit: decodes and executes moves between files
// Assumes the pipeline gives operands in the issue cycle; results one cycle later
// How it works
// - Coprocessor-two major with sub-op zero is word copy; target 20:16, select 15:0.
// - Word copy writes the coprocessor word chosen by the select into target.
// - A missing coprocessor register gives whatever value the coprocessor returns.
// - Float major with sub-op 00011 and low bits zero is upper-half copy.
// - Upper-half copy loads float register bits 63..32 into target.
// - Both upper-half copies are reserved before release two, executed after.
// - Coprocessor-two major with sub-op 00011 is coprocessor upper copy.
// - Coprocessor upper copy takes bits 63..32 of the chosen coprocessor register.
// - Special major, function 010000, zero fields: copy product upper into dest.
// - Product upper copy never raises an exception and sees the newest value.
// - Special major, function 010010, same layout: copy product bottom.
// - Product bottom copy never raises and reflects every earlier write.
// - Float major with bits 20:16 zero and function move is float move.
// - Float move copies source to dest; paired form copies both halves.
// - Float move never raises arithmetic exceptions nor touches flag bits.
// - Paired move in sixteen-register mode gives an unpredictable result.
// - Float move may raise unusable, reserved or unimplemented for bad formats; the code raises only unusable or unimplemented, never reserved.
// - Special major, function 000001, bit 17 zero, true/false bit zero: move-if-false.
// - Move-if-false copies source only when the chosen condition bit is zero.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rmiu_core #(
    parameter logic [2:0] ARCH_RELEASE = 3'h2,
    parameter logic PAIRED_SUPPORTED = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic i_fpu_enabled,
    input wire logic i_coproc_two_opcode_enabled,
    input wire logic i_fpr_width_mode,
    input wire logic [63:0] i_fpr_source_val,
    input wire logic [63:0] i_coproc_two_opcode_val,
    input wire logic [31:0] i_product_upper,
    input wire logic [31:0] i_product_bottom,
    input wire logic [31:0] i_source_reg_val,
    input wire logic [7:0] i_fp_cond_codes,
    output logic o_coproc_two_opcode_rd,
    output logic [15:0] o_coproc_two_opcode_select,
    output logic o_gpr_we,
    output logic [4:0] o_gpr_addr,
    output logic [31:0] o_gpr_data,
    output logic o_fpr_we,
    output logic [4:0] o_fpr_addr,
    output logic [63:0] o_fpr_data,
    output logic o_exc_valid,
    output logic [1:0] o_exc_code,
    output logic o_done
);
    // ==========================================================
    // Field extraction
    logic [5:0] major;
    logic [4:0] sub;
    logic [5:0] func;
    logic [4:0] target_reg;
    logic [4:0] float_source;
    logic [4:0] float_dest;
    logic [4:0] dest_reg;
    logic [2:0] condition_code_select;
    logic true_false_select;
    logic pre_release_two;
    assign major = i_instr[31:26];
    assign sub = i_instr[25:21];
    assign func = i_instr[5:0];
    assign target_reg = i_instr[20:16];
    assign float_source = i_instr[15:11];
    assign float_dest = i_instr[10:6];
    assign dest_reg = i_instr[15:11];
    assign condition_code_select = i_instr[20:18];
    assign true_false_select = i_instr[16];
    assign pre_release_two = ARCH_RELEASE < rmiu_pkg::RELEASE_TWO;

    // Chosen condition bit, kept as a net so checks can look one cycle back
    logic cond_bit;
    assign cond_bit = i_fp_cond_codes[condition_code_select];

    // ==========================================================
    // Decode
    rmiu_pkg::rmiu_op_t op;
    always_comb begin
        op = rmiu_pkg::RMIU_OP_NONE;
        if (major == rmiu_pkg::OP_COPROC_TWO_OPCODE && sub == rmiu_pkg::SUB_MF) begin
            op = rmiu_pkg::RMIU_OP_C2_WORD;
        end else if (major == rmiu_pkg::OP_COPROC_TWO_OPCODE && sub == rmiu_pkg::SUB_MFH) begin
            op = rmiu_pkg::RMIU_OP_C2_UP;
        end else if (major == rmiu_pkg::OP_FPU && sub == rmiu_pkg::SUB_MFH
                && i_instr[10:0] == 11'h000) begin
            op = rmiu_pkg::RMIU_OP_FPR_UP;
        end else if (major == rmiu_pkg::OP_FPU && i_instr[20:16] == 5'h00
                && func == rmiu_pkg::FN_FP_MOV && i_instr[25]) begin
            op = rmiu_pkg::RMIU_OP_FP_MOV;
        end else if (major == rmiu_pkg::OP_SPECIAL && i_instr[25:16] == 10'h000
                && i_instr[10:6] == 5'h00 && func == rmiu_pkg::FN_PROD_UP) begin
            op = rmiu_pkg::RMIU_OP_PROD_UP;
        end else if (major == rmiu_pkg::OP_SPECIAL && i_instr[25:16] == 10'h000
                && i_instr[10:6] == 5'h00 && func == rmiu_pkg::FN_PROD_LO) begin
            op = rmiu_pkg::RMIU_OP_PROD_LO;
        end else if (major == rmiu_pkg::OP_SPECIAL && func == rmiu_pkg::FN_COND_MOVE
                && !i_instr[17] && !true_false_select && i_instr[10:6] == 5'h00) begin
            op = rmiu_pkg::RMIU_OP_MOV_IF_F;
        end
    end

    // ==========================================================
    // Execute: exception and write selection
    logic [1:0] exc_d;
    logic gpr_we_d;
    logic [4:0] gpr_addr_d;
    logic [31:0] gpr_data_d;
    logic fpr_we_d;
    logic fmt_ok;
    always_comb begin
        exc_d = rmiu_pkg::EXC_NONE;
        gpr_we_d = 1'b0;
        gpr_addr_d = target_reg;
        gpr_data_d = 32'h0000_0000;
        fpr_we_d = 1'b0;
        fmt_ok = (sub == rmiu_pkg::FMT_SINGLE) || (sub == rmiu_pkg::FMT_DOUBLE)
            || (sub == rmiu_pkg::FMT_PAIRED && PAIRED_SUPPORTED);
        case (op)
            rmiu_pkg::RMIU_OP_C2_WORD: begin
                if (!i_coproc_two_opcode_enabled) begin
                    exc_d = rmiu_pkg::EXC_COP_UNUSABLE;
                end else begin
                    gpr_we_d = 1'b1;
                    gpr_data_d = i_coproc_two_opcode_val[31:0];
                end
            end
            rmiu_pkg::RMIU_OP_C2_UP: begin
                if (!i_coproc_two_opcode_enabled) begin
                    exc_d = rmiu_pkg::EXC_COP_UNUSABLE;
                end else if (pre_release_two) begin
                    exc_d = rmiu_pkg::EXC_RESERVED;
                end else begin
                    gpr_we_d = 1'b1;
                    gpr_data_d = i_coproc_two_opcode_val[63:32];
                end
            end
            rmiu_pkg::RMIU_OP_FPR_UP: begin
                if (!i_fpu_enabled) begin
                    exc_d = rmiu_pkg::EXC_COP_UNUSABLE;
                end else if (pre_release_two) begin
                    exc_d = rmiu_pkg::EXC_RESERVED;
                end else begin
                    gpr_we_d = 1'b1;
                    gpr_data_d = i_fpr_source_val[63:32];
                end
            end
            rmiu_pkg::RMIU_OP_FP_MOV: begin
                if (!i_fpu_enabled) begin
                    exc_d = rmiu_pkg::EXC_COP_UNUSABLE;
                end else if (!fmt_ok) begin
                    exc_d = rmiu_pkg::EXC_UNIMPL_OP;
                end else begin
                    // Flags are never touched: no arithmetic path exists here
                    fpr_we_d = 1'b1;
                end
            end
            rmiu_pkg::RMIU_OP_PROD_UP: begin
                gpr_we_d = 1'b1;
                gpr_addr_d = dest_reg;
                gpr_data_d = i_product_upper;
            end
            rmiu_pkg::RMIU_OP_PROD_LO: begin
                gpr_we_d = 1'b1;
                gpr_addr_d = dest_reg;
                gpr_data_d = i_product_bottom;
            end
            rmiu_pkg::RMIU_OP_MOV_IF_F: begin
                gpr_addr_d = dest_reg;
                gpr_data_d = i_source_reg_val;
                if (!i_fpu_enabled) begin
                    exc_d = rmiu_pkg::EXC_COP_UNUSABLE;
                end else begin
                    gpr_we_d = !i_fp_cond_codes[condition_code_select];
                end
            end
            default: begin
                exc_d = rmiu_pkg::EXC_NONE;
            end
        endcase
    end

    // ==========================================================
    // Output registers
    logic issue;
    assign issue = i_valid && (op != rmiu_pkg::RMIU_OP_NONE);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_gpr_we <= 1'b0;
            o_gpr_addr <= 5'h00;
            o_fpr_we <= 1'b0;
            o_fpr_addr <= 5'h00;
            o_exc_valid <= 1'b0;
            o_exc_code <= rmiu_pkg::EXC_NONE;
            o_done <= 1'b0;
            o_coproc_two_opcode_rd <= 1'b0;
            o_coproc_two_opcode_select <= 16'h0000;
        end else begin
            o_gpr_we <= issue && gpr_we_d;
            o_gpr_addr <= gpr_addr_d;
            o_fpr_we <= issue && fpr_we_d;
            o_fpr_addr <= float_dest;
            o_exc_valid <= issue && (exc_d != rmiu_pkg::EXC_NONE);
            o_exc_code <= issue ? exc_d : rmiu_pkg::EXC_NONE;
            o_done <= issue;
            o_coproc_two_opcode_rd <= issue && i_coproc_two_opcode_enabled && major == rmiu_pkg::OP_COPROC_TWO_OPCODE;
            o_coproc_two_opcode_select <= i_instr[15:0];
        end
    end

    // Whole 64 bits moved so the paired form carries both halves
    rmiu_result_reg #(.W(64)) u_fpr_data (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_load(issue && fpr_we_d),
        .i_d(i_fpr_source_val),
        .o_q(o_fpr_data)
    );

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_gpr_data <= 32'h0000_0000;
        end else if (issue) begin
            o_gpr_data <= gpr_data_d;
        end
    end

    // ==========================================================
    // Checks
    AST_C2_WORD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_C2_WORD && i_coproc_two_opcode_enabled)
        |=> (o_gpr_we && o_gpr_data == $past(i_coproc_two_opcode_val[31:0])))
        else $error("coprocessor word copy wrong");
    AST_FPR_UP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_FPR_UP && i_fpu_enabled && !pre_release_two)
        |=> (o_gpr_data == $past(i_fpr_source_val[63:32])))
        else $error("float upper copy wrong");
    AST_C2_UP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_C2_UP && i_coproc_two_opcode_enabled && !pre_release_two)
        |=> (o_gpr_data == $past(i_coproc_two_opcode_val[63:32])))
        else $error("coprocessor upper copy wrong");
    AST_PROD_UP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_PROD_UP)
        |=> (o_gpr_we && !o_exc_valid && o_gpr_data == $past(i_product_upper)))
        else $error("product upper copy wrong");
    AST_PROD_LO: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_PROD_LO)
        |=> (o_gpr_we && !o_exc_valid && o_gpr_data == $past(i_product_bottom)))
        else $error("product bottom copy wrong");
    AST_FP_MOV: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_FP_MOV && i_fpu_enabled && fmt_ok)
        |=> (o_fpr_we && o_fpr_data == $past(i_fpr_source_val)))
        else $error("float move wrong");
    AST_MOV_IF_F: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && op == rmiu_pkg::RMIU_OP_MOV_IF_F && i_fpu_enabled)
        |=> (o_gpr_we == !$past(cond_bit)))
        else $error("move if false wrong");
    AST_UNUSABLE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_valid && major == rmiu_pkg::OP_COPROC_TWO_OPCODE && op != rmiu_pkg::RMIU_OP_NONE
            && !i_coproc_two_opcode_enabled)
        |=> (!o_gpr_we && o_exc_code == rmiu_pkg::EXC_COP_UNUSABLE))
        else $error("disabled coprocessor not refused");

    // ==========================================================
    // Cause and answer checks, all but AST_EXC_NO_WRITE and AST_ONE_FILE built from named sequences
    // Each sequence names one kind of issue or answer so every property but AST_ONE_FILE reads cause, then answer
    sequence s_upper_early;
        i_valid && pre_release_two
            && ((op == rmiu_pkg::RMIU_OP_C2_UP && i_coproc_two_opcode_enabled)
            || (op == rmiu_pkg::RMIU_OP_FPR_UP && i_fpu_enabled));
    endsequence
    sequence s_fpu_off;
        i_valid && !i_fpu_enabled && (op == rmiu_pkg::RMIU_OP_FPR_UP
            || op == rmiu_pkg::RMIU_OP_FP_MOV || op == rmiu_pkg::RMIU_OP_MOV_IF_F);
    endsequence
    sequence s_bad_fmt;
        i_valid && op == rmiu_pkg::RMIU_OP_FP_MOV && i_fpu_enabled && !fmt_ok;
    endsequence
    sequence s_fp_mov_ok;
        i_valid && op == rmiu_pkg::RMIU_OP_FP_MOV && i_fpu_enabled && fmt_ok;
    endsequence
    sequence s_c2_ok;
        i_valid && i_coproc_two_opcode_enabled
            && (op == rmiu_pkg::RMIU_OP_C2_WORD || op == rmiu_pkg::RMIU_OP_C2_UP);
    endsequence
    sequence s_prod;
        i_valid && (op == rmiu_pkg::RMIU_OP_PROD_UP || op == rmiu_pkg::RMIU_OP_PROD_LO);
    endsequence
    sequence s_mov_write;
        i_valid && op == rmiu_pkg::RMIU_OP_MOV_IF_F && i_fpu_enabled && !cond_bit;
    endsequence
    sequence s_no_issue;
        !i_valid || op == rmiu_pkg::RMIU_OP_NONE;
    endsequence
    sequence s_quiet;
        !o_done && !o_gpr_we && !o_fpr_we && !o_exc_valid;
    endsequence

    AST_RESERVED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_upper_early
        |=> (o_exc_valid && o_exc_code == rmiu_pkg::EXC_RESERVED && !o_gpr_we))
        else $error("early release upper copy not reserved");
    AST_FPU_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_fpu_off
        |=> (!o_gpr_we && !o_fpr_we && o_exc_code == rmiu_pkg::EXC_COP_UNUSABLE))
        else $error("disabled float unit not refused");
    AST_UNIMPL: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_bad_fmt
        |=> (!o_fpr_we && o_exc_code == rmiu_pkg::EXC_UNIMPL_OP))
        else $error("unsupported format not refused");
    AST_FP_MOV_DEST: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_fp_mov_ok
        |=> (!o_exc_valid && o_fpr_addr == $past(float_dest)))
        else $error("float move destination or flags wrong");
    AST_C2_SELECT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_c2_ok
        |=> (o_coproc_two_opcode_rd && o_coproc_two_opcode_select == $past(i_instr[15:0])
            && o_gpr_addr == $past(target_reg)))
        else $error("coprocessor select or target wrong");
    AST_PROD_DEST: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_prod
        |=> (o_gpr_addr == $past(dest_reg) && o_done))
        else $error("product copy destination wrong");
    AST_MOV_IF_F_DATA: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_mov_write
        |=> (o_gpr_data == $past(i_source_reg_val) && o_gpr_addr == $past(dest_reg)))
        else $error("move if false data wrong");
    AST_IGNORED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_no_issue |=> s_quiet)
        else $error("output raised without an issue");
    AST_EXC_NO_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_exc_valid |-> (!o_gpr_we && !o_fpr_we && o_done))
        else $error("write beside an exception");
    AST_ONE_FILE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !(o_gpr_we && o_fpr_we))
        else $error("both register files written at once");
    AST_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (s_prod ##1 s_no_issue) |=> s_quiet)
        else $error("answer held longer than one cycle");
endmodule
`default_nettype wire

// [verification/rmiu_far_model.sv]
// Far-side model: floating-point unit, second coprocessor and host operand paths
// Assumes operands are read in the issue cycle; a salt word varies every value per cycle
`timescale 1ns/1ns
`default_nettype none
module rmiu_far_model (
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_salt,
    output logic [63:0] o_fpr_source_val,
    output logic [63:0] o_coproc_two_opcode_val,
    output logic [31:0] o_product_upper,
    output logic [31:0] o_product_bottom,
    output logic [31:0] o_source_reg_val,
    output logic [7:0] o_fp_cond_codes
);
    // ==========================================================
    // Operand values
    // Both halves differ so a swapped or truncated copy shows up
    assign o_fpr_source_val = {i_salt, ~i_salt ^ {27'h0, i_instr[15:11]}};
    // Any select answers, a missing register included; no value is promised there
    assign o_coproc_two_opcode_val = {i_salt ^ {16'h0, i_instr[15:0]}, ~i_salt};
    assign o_product_upper = {i_salt[15:0], i_salt[31:16]};
    assign o_product_bottom = i_salt ^ 32'h5a5a_a5a5;
    assign o_source_reg_val = i_salt ^ {27'h0, i_instr[25:21]};
    assign o_fp_cond_codes = i_salt[7:0] ^ i_salt[15:8];
endmodule
`default_nettype wire

// [verification/rmiu_core_tb.sv]
// Self-checking bench for the register move instruction unit
// Assumes the far-side model supplies operands in the issue cycle
`timescale 1ns/1ns
`default_nettype none
module rmiu_core_tb;
    typedef struct packed {
        logic done, gwe, fwe, exv, c2;
        logic [1:0] exc;
        logic [4:0] gaddr, faddr;
        logic [15:0] sel;
        logic [31:0] gdata;
        logic [63:0] fdata;
    } rmiu_exp_t;
    logic i_mclk, i_rst_b, i_valid, i_fpu_enabled, i_coproc_two_opcode_enabled, i_fpr_width_mode;
    logic [31:0] i_instr, salt, i_product_upper, i_product_bottom, i_source_reg_val, rng, w;
    logic [63:0] i_fpr_source_val, i_coproc_two_opcode_val;
    logic [7:0] i_fp_cond_codes;
    logic o_coproc_two_opcode_rd, o_gpr_we, o_fpr_we, o_exc_valid, o_done, have;
    logic [15:0] o_coproc_two_opcode_select;
    logic [4:0] o_gpr_addr, o_fpr_addr;
    logic [31:0] o_gpr_data;
    logic [63:0] o_fpr_data;
    logic [1:0] o_exc_code;
    int err_count, samples_checked;
    rmiu_exp_t exp_q;
    logic [31:0] corner [10] = '{32'h0000_5010, 32'h4803_abcd, 32'h4867_ffff, 32'h447f_f000,
        32'h0000_f812, 32'h46c0_10c6, 32'h4680_10c6, 32'h013c_2801, 32'h0000_5050, 32'h013d_2801};

    rmiu_core i_dut (.i_mclk, .i_rst_b, .i_valid, .i_instr, .i_fpu_enabled, .i_coproc_two_opcode_enabled,
        .i_fpr_width_mode, .i_fpr_source_val, .i_coproc_two_opcode_val, .i_product_upper, .i_product_bottom,
        .i_source_reg_val, .i_fp_cond_codes, .o_coproc_two_opcode_rd, .o_coproc_two_opcode_select, .o_gpr_we, .o_gpr_addr,
        .o_gpr_data, .o_fpr_we, .o_fpr_addr, .o_fpr_data, .o_exc_valid, .o_exc_code, .o_done);
    rmiu_far_model i_far (.i_instr, .i_salt(salt), .o_fpr_source_val(i_fpr_source_val),
        .o_coproc_two_opcode_val(i_coproc_two_opcode_val), .o_product_upper(i_product_upper),
        .o_product_bottom(i_product_bottom), .o_source_reg_val(i_source_reg_val),
        .o_fp_cond_codes(i_fp_cond_codes));

    // ==========================================================
    // Clock and watchdog
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction

    function automatic logic [31:0] tmpl(input logic [31:0] r);
        logic [4:0] fmt;
        fmt = r[4] ? rmiu_pkg::FMT_PAIRED : (r[3] ? rmiu_pkg::FMT_DOUBLE : {1'b1, r[24:21]});
        case (r[2:0])
            3'd0: return {6'h12, 5'h00, r[20:0]};
            3'd1: return {6'h12, 5'h03, r[20:0]};
            3'd2: return {6'h11, 5'h03, r[20:11], 11'h0};
            3'd3: return {16'h0, r[15:11], 5'h0, 6'h10};
            3'd4: return {16'h0, r[15:11], 5'h0, 6'h12};
            3'd5: return {6'h11, fmt, 5'h0, r[15:6], 6'h06};
            3'd6: return {6'h0, r[25:18], 2'b0, r[15:11], 5'h0, 6'h01};
            default: return r;
        endcase
    endfunction

    function automatic rmiu_exp_t predict(input logic [31:0] x);
        rmiu_exp_t e;
        e = '0;
        if (x[31:26] == rmiu_pkg::OP_COPROC_TWO_OPCODE && (x[25:21] == 5'h00 || x[25:21] == 5'h03)) begin
            e.done = 1'b1;
            e.exv = !i_coproc_two_opcode_enabled;
            e.exc = rmiu_pkg::EXC_COP_UNUSABLE;
            {e.gwe, e.c2, e.gaddr, e.sel} = {{2{i_coproc_two_opcode_enabled}}, x[20:0]};
            e.gdata = x[21] ? i_coproc_two_opcode_val[63:32] : i_coproc_two_opcode_val[31:0];
        end else if (x[31:26] == rmiu_pkg::OP_FPU && x[25:21] == 5'h03 && x[10:0] == 11'h0) begin
            {e.done, e.exv, e.exc} = {1'b1, !i_fpu_enabled, rmiu_pkg::EXC_COP_UNUSABLE};
            {e.gwe, e.gaddr, e.gdata} = {i_fpu_enabled, x[20:16], i_fpr_source_val[63:32]};
        end else if (x[31:25] == 7'h23 && x[20:16] == 5'h0 && x[5:0] == rmiu_pkg::FN_FP_MOV) begin
            e.done = 1'b1;
            if (!i_fpu_enabled) {e.exv, e.exc} = {1'b1, rmiu_pkg::EXC_COP_UNUSABLE};
            else if (x[25:21] != 5'h10 && x[25:21] != 5'h11 && x[25:21] != 5'h16)
                {e.exv, e.exc} = {1'b1, rmiu_pkg::EXC_UNIMPL_OP};
            else {e.fwe, e.faddr, e.fdata} = {1'b1, x[10:6], i_fpr_source_val};
        end else if (x[31:26] == 6'h0 && x[10:6] == 5'h0) begin
            if (x[25:16] == 10'h0 && (x[5:0] == 6'h10 || x[5:0] == 6'h12))
                {e.done, e.gwe, e.gaddr, e.gdata} = {2'b11, x[15:11],
                    x[1] ? i_product_bottom : i_product_upper};
            else if (x[5:0] == 6'h01 && x[17:16] == 2'b00)
                {e.done, e.gwe, e.gaddr, e.gdata} = {1'b1, !i_fp_cond_codes[x[20:18]],
                    x[15:11], i_source_reg_val};
        end
        return e;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic compare(input rmiu_exp_t e);
        chk(o_gpr_we, e.gwe);
        chk(o_fpr_we, e.fwe);
        chk(o_exc_valid, e.exv);
        if (e.exv) chk(o_exc_code, e.exc);
        else chk(o_done, e.done);
        if (e.gwe) chk({o_gpr_addr, o_gpr_data}, {e.gaddr, e.gdata});
        if (e.fwe) chk({o_fpr_addr, o_fpr_data[63:32]}, {e.faddr, e.fdata[63:32]});
        if (e.fwe) chk(o_fpr_data, e.fdata);
        if (e.c2) chk({o_coproc_two_opcode_rd, o_coproc_two_opcode_select}, {1'b1, e.sel});
    endtask

    // One issue cycle; the answer to the previous issue is checked first
    task automatic step(input logic [31:0] x, input logic en, input logic v, input logic rb);
        @(posedge i_mclk);
        rng = xs(rng);
        i_rst_b <= rb;
        i_valid <= v;
        i_instr <= x;
        salt <= rng;
        i_coproc_two_opcode_enabled <= en;
        i_fpu_enabled <= en | (x[31:26] == 6'h0);
        // Paired moves in the narrow register mode have no defined result
        i_fpr_width_mode <= rng[5] | (x[25:21] == rmiu_pkg::FMT_PAIRED);
        @(negedge i_mclk);
        if (have) compare(exp_q);
        exp_q = (rb && v) ? predict(x) : '0;
        have = 1'b1;
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {i_rst_b, i_valid, i_fpu_enabled, i_coproc_two_opcode_enabled, i_fpr_width_mode, have} = '0;
        {i_instr, salt} = '0;
        err_count = 0;
        samples_checked = 0;
        rng = 32'd75745;
        repeat (3) step(32'h0, 1'b1, 1'b0, 1'b0);
        foreach (corner[k]) begin
            step(corner[k], 1'b1, 1'b1, 1'b1);
            step(corner[k], 1'b0, 1'b1, 1'b1);
        end
        for (int k = 0; k < 2000; k++) begin
            w = tmpl(rng);
            if (rng[31:29] == 3'h0) w ^= 32'h1 << rng[28:24];
            step(w, rng[23:20] != 4'h0, rng[19:18] != 2'h0, !(k == 900 || k == 901));
        end
        step(32'h0, 1'b1, 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
